// ==== sbwrap_core.sv ====
`timescale 1ns/1ps
`include "sbwrap_defines.svh"

// Overview of operation
// - every transfer runs eight data cycles; all but double-pumped fills move a 64-byte block, all bytes valid
// - received data goes to the 16-byte internal bus only after two beats arrive
// - I/O target is named by outbound address bits 5:3 plus an 8-bit mask
// - quad I/O: first quadword address in 5:3, mask marks merged quadwords ascending
// - long I/O: first longword address in 5:3, mask marks longwords in one hexword
// - byte/word I/O: quadword address in 5:3, mask picks the valid bytes
// - command bits 4:2 encode fill, fill modified, fill shared, shared modified, drain
// - block, quad reads and all I/O writes run eight quadwords, start from 5:4
// - double-pumped start follows bits 4:3 or system choice, sent in bits 1:0
// - eight-cycle transfers send quadword start XOR cycle number
// - double-pumped pair k carries quadword with bits 4:3 equal start XOR k

module sbwrap_core #(
  parameter int BEATS = `SBWRAP_BEATS,
  parameter int QW_W = `SBWRAP_QW_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // system data bus pins
  input wire logic cmd_valid_pin,
  input wire logic [4:0] data_movement_command,
  input wire logic data_beat_pin,
  input wire logic [QW_W-1:0] sys_data_in,
  output logic [QW_W-1:0] sys_data_out,
  output logic sys_data_out_en,
  // outbound I/O address and mask
  output logic io_cmd_valid,
  output logic [2:0] outbound_address_bus,
  output logic [7:0] outbound_mask,
  output logic io_cmd_write,
  // core side I/O request
  input wire logic io_req_valid,
  input wire logic io_req_write,
  input wire sbwrap_pkg::sbwrap_io_kind_t io_req_kind,
  input wire logic [5:0] io_req_pa,
  input wire logic [7:0] io_req_mask,
  // core side fill tagging and drain source
  input wire logic fill_double,
  output logic [2:0] drain_index,
  input wire logic [QW_W-1:0] drain_qw,
  // internal 16-byte bus
  output logic octa_valid,
  output sbwrap_pkg::sbwrap_octaword_t octa,
  output logic transfer_done
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (BEATS != 8) $error("sbwrap_core: wrap order is defined for eight beats only");
  if (QW_W != 64) $error("sbwrap_core: quadword width must be 64");

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [2:0] wrap_index(input logic [2:0] start, input logic [2:0] beat, input logic dbl);
    logic [2:0] r;
    r = 3'h0;
    if (dbl)
    begin
      r = {1'b0, start[1:0] ^ beat[2:1]};
    end
    else
    begin
      r = start ^ beat;
    end
    return r;
  endfunction : wrap_index

  function automatic logic [7:0] byte_select(input logic [2:0] low, input logic is_word);
    logic [7:0] r;
    r = 8'h01 << low;
    if (is_word)
    begin
      r = 8'h03 << {low[2:1], 1'b0};
    end
    return r;
  endfunction : byte_select

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // data is synchronised with its strobe so a beat and its word never split
  logic cmd_valid_s1_reg, cmd_valid_s2_reg;
  logic [4:0] cmd_s1_reg, cmd_s2_reg;
  logic beat_s1_reg, beat_s2_reg;
  logic [QW_W-1:0] data_s1_reg, data_s2_reg;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cmd_valid_s1_reg <= 1'b0;
      cmd_valid_s2_reg <= 1'b0;
      beat_s1_reg <= 1'b0;
      beat_s2_reg <= 1'b0;
      cmd_s1_reg <= 5'h00;
      cmd_s2_reg <= 5'h00;
      data_s1_reg <= '0;
      data_s2_reg <= '0;
    end
    else
    begin
      cmd_valid_s1_reg <= cmd_valid_pin;
      cmd_valid_s2_reg <= cmd_valid_s1_reg;
      beat_s1_reg <= data_beat_pin;
      beat_s2_reg <= beat_s1_reg;
      cmd_s1_reg <= data_movement_command;
      cmd_s2_reg <= cmd_s1_reg;
      data_s1_reg <= sys_data_in;
      data_s2_reg <= data_s1_reg;
    end
  end

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  wire [2:0] cmd_op = cmd_s2_reg[`SBWRAP_CMD_OP_HI:`SBWRAP_CMD_OP_LO];
  wire [1:0] cmd_start = cmd_s2_reg[`SBWRAP_CMD_START_HI:`SBWRAP_CMD_START_LO];
  wire cmd_is_fill = cmd_op[2];
  wire cmd_is_drain = (cmd_op == `SBWRAP_OP_DRAIN_DATA);

  sbwrap_pkg::sbwrap_state_t state_reg, state_next;
  logic [2:0] beat_cnt_reg;
  logic [2:0] start_reg;
  logic double_reg;
  logic [QW_W-1:0] held_qw_reg;
  logic [2:0] held_idx_reg;

  wire idle = (state_reg == sbwrap_pkg::SBWRAP_IDLE);
  wire start_fill = idle && cmd_valid_s2_reg && cmd_is_fill;
  wire start_drain = idle && cmd_valid_s2_reg && cmd_is_drain;
  wire fill_beat = (state_reg == sbwrap_pkg::SBWRAP_FILL) && beat_s2_reg;
  wire drain_beat = (state_reg == sbwrap_pkg::SBWRAP_DRAIN);
  wire any_beat = fill_beat || drain_beat;
  wire last_beat = any_beat && (beat_cnt_reg == `SBWRAP_LAST_BEAT);
  // a double-pumped fill wraps on the 2-bit start, the rest on a 3-bit start
  wire [2:0] cur_index = wrap_index(start_reg, beat_cnt_reg, double_reg);

  // ----------------------------------------
  // transfer sequencing
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      sbwrap_pkg::SBWRAP_IDLE:
      begin
        if (start_fill)
        begin
          state_next = sbwrap_pkg::SBWRAP_FILL;
        end
        else if (start_drain)
        begin
          state_next = sbwrap_pkg::SBWRAP_DRAIN;
        end
      end
      sbwrap_pkg::SBWRAP_FILL, sbwrap_pkg::SBWRAP_DRAIN:
      begin
        if (last_beat)
        begin
          state_next = sbwrap_pkg::SBWRAP_IDLE;
        end
      end
      default:
      begin
        state_next = sbwrap_pkg::SBWRAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= sbwrap_pkg::SBWRAP_IDLE;
      beat_cnt_reg <= `SBWRAP_RESET_CNT;
      start_reg <= 3'h0;
      double_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (start_fill || start_drain)
      begin
        // start comes from the system in bits 1:0, always honoured
        start_reg <= start_fill && fill_double ? {1'b0, cmd_start} : {cmd_start, 1'b0};
        double_reg <= start_fill && fill_double;
        beat_cnt_reg <= `SBWRAP_RESET_CNT;
      end
      else if (any_beat)
      begin
        beat_cnt_reg <= beat_cnt_reg + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // fill pairing onto the internal bus
  // ----------------------------------------
  wire pair_done = fill_beat && beat_cnt_reg[0];

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      held_qw_reg <= '0;
      held_idx_reg <= 3'h0;
      octa_valid <= 1'b0;
      octa <= '0;
      transfer_done <= 1'b0;
    end
    else
    begin
      if (fill_beat && !beat_cnt_reg[0])
      begin
        held_qw_reg <= data_s2_reg;
        held_idx_reg <= cur_index;
      end
      octa_valid <= pair_done;
      if (pair_done)
      begin
        octa.data_lo <= held_qw_reg;
        octa.index_lo <= held_idx_reg;
        octa.data_hi <= data_s2_reg;
        octa.index_hi <= cur_index;
      end
      transfer_done <= last_beat;
    end
  end

  // ----------------------------------------
  // drain to the system
  // ----------------------------------------
  assign drain_index = cur_index;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sys_data_out <= '0;
      sys_data_out_en <= 1'b0;
    end
    else
    begin
      sys_data_out_en <= drain_beat;
      if (drain_beat)
      begin
        sys_data_out <= drain_qw;
      end
    end
  end

  // ----------------------------------------
  // outbound I/O address and mask
  // ----------------------------------------
  // quad and long accesses pass the merge mask through; byte and word build it here
  wire is_sub_quad = (io_req_kind == sbwrap_pkg::SBWRAP_IO_BYTE) || (io_req_kind == sbwrap_pkg::SBWRAP_IO_WORD);
  wire [7:0] sub_mask = byte_select(io_req_pa[2:0], io_req_kind == sbwrap_pkg::SBWRAP_IO_WORD);
  wire [7:0] req_mask = is_sub_quad ? sub_mask : io_req_mask;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      io_cmd_valid <= 1'b0;
      outbound_address_bus <= `SBWRAP_RESET_ADDR;
      outbound_mask <= `SBWRAP_RESET_MASK;
      io_cmd_write <= 1'b0;
    end
    else
    begin
      io_cmd_valid <= io_req_valid;
      if (io_req_valid)
      begin
        outbound_address_bus <= io_req_pa[5:3];
        outbound_mask <= req_mask;
        io_cmd_write <= io_req_write;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence drain_run;
    sys_data_out_en [*8];
  endsequence

  sequence fill_start_seen;
    start_fill ##1 (state_reg == sbwrap_pkg::SBWRAP_FILL);
  endsequence

  a_drain_eight_cycles: assert property (@(posedge core_clk) disable iff (!rst_n)
    start_drain |=> ##1 drain_run ##1 !sys_data_out_en)
    else $error("drain did not run exactly eight cycles");

  a_fill_enters_state: assert property (@(posedge core_clk) disable iff (!rst_n)
    (idle && cmd_valid_s2_reg && cmd_s2_reg[4]) |-> fill_start_seen)
    else $error("fill command did not start a fill");

  a_octa_after_pair: assert property (@(posedge core_clk) disable iff (!rst_n)
    octa_valid |-> $past(fill_beat) && $past(beat_cnt_reg[0]))
    else $error("octaword forwarded before two beats");

  a_block_pair_order: assert property (@(posedge core_clk) disable iff (!rst_n)
    (octa_valid && !double_reg) |-> (octa.index_hi == (octa.index_lo ^ 3'h1)))
    else $error("block octaword halves not interleaved");

  a_double_pair_same: assert property (@(posedge core_clk) disable iff (!rst_n)
    (octa_valid && double_reg) |-> (octa.index_hi == octa.index_lo))
    else $error("double-pumped pair carried two quadwords");

  a_drain_wrap_xor: assert property (@(posedge core_clk) disable iff (!rst_n)
    (drain_beat && beat_cnt_reg == 3'h5) |-> (drain_index == (start_reg ^ 3'h5)))
    else $error("drain index off the interleave order");

  a_block_start_cmd: assert property (@(posedge core_clk) disable iff (!rst_n)
    (start_drain) |=> (start_reg == {$past(cmd_start), 1'b0}) && (drain_index == start_reg))
    else $error("drain did not start at commanded quadword");

  a_fill_ends_eight: assert property (@(posedge core_clk) disable iff (!rst_n)
    (fill_beat && beat_cnt_reg == `SBWRAP_LAST_BEAT) |=> idle && transfer_done)
    else $error("fill did not end after eight beats");

  a_io_addr_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
    io_req_valid |=> io_cmd_valid && (outbound_address_bus == $past(io_req_pa[5:3])))
    else $error("outbound address bits 5:3 wrong");

  a_byte_mask_onehot: assert property (@(posedge core_clk) disable iff (!rst_n)
    (io_req_valid && io_req_kind == sbwrap_pkg::SBWRAP_IO_BYTE) |=> $onehot(outbound_mask))
    else $error("byte access mask not one-hot");

  a_merge_mask_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
    (io_req_valid && !is_sub_quad) |=> (outbound_mask == $past(io_req_mask)))
    else $error("merge mask altered");

endmodule : sbwrap_core

// ==== sbwrap_defines.svh ====
`ifndef SBWRAP_DEFINES_SVH
`define SBWRAP_DEFINES_SVH

// ----------------------------------------
// data movement command fields
// ----------------------------------------
`define SBWRAP_CMD_W 5
`define SBWRAP_CMD_OP_HI 4
`define SBWRAP_CMD_OP_LO 2
`define SBWRAP_CMD_START_HI 1
`define SBWRAP_CMD_START_LO 0
`define SBWRAP_OP_FILL_DATA 3'h4
`define SBWRAP_OP_FILL_MODIFIED 3'h5
`define SBWRAP_OP_FILL_SHARED 3'h6
`define SBWRAP_OP_FILL_SHARED_MOD 3'h7
`define SBWRAP_OP_DRAIN_DATA 3'h2

// ----------------------------------------
// transfer geometry
// ----------------------------------------
`define SBWRAP_BEATS 8
`define SBWRAP_BLOCK_BYTES 64
`define SBWRAP_QW_W 64
`define SBWRAP_LAST_BEAT 3'h7
`define SBWRAP_RESET_CNT 3'h0
`define SBWRAP_RESET_MASK 8'h00
`define SBWRAP_RESET_ADDR 3'h0

`endif

// ==== sbwrap_pkg.sv ====
package sbwrap_pkg;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    SBWRAP_IO_QUAD,
    SBWRAP_IO_LONG,
    SBWRAP_IO_BYTE,
    SBWRAP_IO_WORD
  } sbwrap_io_kind_t;

  typedef enum logic [1:0] {
    SBWRAP_IDLE,
    SBWRAP_FILL,
    SBWRAP_DRAIN
  } sbwrap_state_t;

  typedef struct packed {
    logic [63:0] data_hi;
    logic [63:0] data_lo;
    logic [2:0] index_hi;
    logic [2:0] index_lo;
  } sbwrap_octaword_t;

  typedef struct packed {
    logic write;
    sbwrap_io_kind_t kind;
    logic [2:0] address;
    logic [7:0] mask;
  } sbwrap_outbound_t;

endpackage : sbwrap_pkg

// ==== sbwrap_sys_model.sv ====
`timescale 1ns/1ps

module sbwrap_sys_model (
  // clock
  core_clk,
  // system data bus
  cmd_valid_pin,
  data_movement_command,
  data_beat_pin,
  sys_data_in,
  // completion
  transfer_done
);
  input wire logic core_clk;
  output logic cmd_valid_pin;
  output logic [4:0] data_movement_command;
  output logic data_beat_pin;
  output logic [63:0] sys_data_in;
  input wire logic transfer_done;

  // --------------------------------
  // expected results, popped by the bench
  // --------------------------------
  sbwrap_pkg::sbwrap_octaword_t oq[$];
  logic [63:0] dq[$];

  initial
  begin
    cmd_valid_pin = 1'b0;
    data_movement_command = 5'h00;
    data_beat_pin = 1'b0;
    sys_data_in = 64'h0;
  end

  function automatic logic [63:0] pat(input logic [2:0] i);
    pat = {8{5'h15, i}};
  endfunction : pat

  // released lines show the inverse so stale values never match by luck
  task automatic send_cmd(input logic [2:0] op, input logic [1:0] st);
    @(negedge core_clk);
    cmd_valid_pin = 1'b1;
    data_movement_command = {op, st};
    @(negedge core_clk);
    cmd_valid_pin = 1'b0;
    data_movement_command = ~data_movement_command;
  endtask : send_cmd

  task automatic wait_done();
    int t;
    // read the pulse at the falling edge, where it has settled
    for (t = 0; t < 40 && transfer_done !== 1'b1; t++)
      @(negedge core_clk);
  endtask : wait_done

  // gap idles the beat strobe between octawords, as a slow system may
  task automatic fill(input logic [2:0] op, input logic [1:0] st, input logic dbl, input int gap);
    logic [2:0] ix[8];
    int n;
    for (n = 0; n < 8; n++)
      ix[n] = dbl ? {1'b0, st ^ 2'(n >> 1)} : {st, 1'b0} ^ 3'(n);
    for (n = 0; n < 8 && op[2]; n += 2)
      oq.push_back({pat(ix[n+1]), pat(ix[n]), ix[n+1], ix[n]});
    send_cmd(op, st);
    repeat (2) @(negedge core_clk);
    for (n = 0; n < 8; n++)
    begin
      @(negedge core_clk);
      data_beat_pin = 1'b1;
      sys_data_in = pat(ix[n]);
      if (n[0] && n < 7 && gap > 0)
      begin
        @(negedge core_clk);
        data_beat_pin = 1'b0;
        sys_data_in = ~sys_data_in;
        repeat (gap - 1) @(negedge core_clk);
      end
    end
    @(negedge core_clk);
    data_beat_pin = 1'b0;
    sys_data_in = ~sys_data_in;
    if (op[2])
      wait_done();
  endtask : fill

  task automatic drain(input logic [1:0] st);
    int n;
    for (n = 0; n < 8; n++)
      dq.push_back(pat({st, 1'b0} ^ 3'(n)));
    send_cmd(3'h2, st);
    wait_done();
  endtask : drain
endmodule : sbwrap_sys_model

// ==== sbwrap_tb.sv ====
`timescale 1ns/1ps

module testbench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid_pin, data_beat_pin, sys_data_out_en, io_cmd_valid, io_cmd_write;
  logic [4:0] data_movement_command;
  logic [63:0] sys_data_in, sys_data_out, drain_qw = 64'h0;
  logic [2:0] outbound_address_bus, drain_index;
  logic [7:0] outbound_mask, io_req_mask = 8'h00;
  logic io_req_valid = 1'b0, io_req_write = 1'b0, fill_double = 1'b0;
  sbwrap_pkg::sbwrap_io_kind_t io_req_kind = sbwrap_pkg::SBWRAP_IO_QUAD;
  logic [5:0] io_req_pa = 6'h00;
  logic octa_valid, transfer_done;
  sbwrap_pkg::sbwrap_octaword_t octa;
  logic [11:0] iq[$];
  int n_fail = 0, n_checks = 0, n_done = 0, seed = 32'haff6, i;

  always #4 core_clk = ~core_clk;

  sbwrap_core u_dut (.core_clk(core_clk), .rst_n(rst_n), .cmd_valid_pin(cmd_valid_pin),
    .data_movement_command(data_movement_command), .data_beat_pin(data_beat_pin),
    .sys_data_in(sys_data_in), .sys_data_out(sys_data_out), .sys_data_out_en(sys_data_out_en),
    .io_cmd_valid(io_cmd_valid), .outbound_address_bus(outbound_address_bus),
    .outbound_mask(outbound_mask), .io_cmd_write(io_cmd_write), .io_req_valid(io_req_valid),
    .io_req_write(io_req_write), .io_req_kind(io_req_kind), .io_req_pa(io_req_pa),
    .io_req_mask(io_req_mask), .fill_double(fill_double), .drain_index(drain_index),
    .drain_qw(drain_qw), .octa_valid(octa_valid), .octa(octa), .transfer_done(transfer_done));

  sbwrap_sys_model u_sys (.core_clk(core_clk), .cmd_valid_pin(cmd_valid_pin),
    .data_movement_command(data_movement_command), .data_beat_pin(data_beat_pin),
    .sys_data_in(sys_data_in), .transfer_done(transfer_done));

  // --------------------------------
  // compare tasks
  // --------------------------------
  task automatic fail(input string m);
    n_fail++;
    $display("Error %0t: %s", $time, m);
  endtask : fail

  task automatic chk_octa(input sbwrap_pkg::sbwrap_octaword_t v);
    n_checks++;
    if (u_sys.oq.size() == 0) fail("unexpected octaword");
    else if (u_sys.oq.pop_front() !== v) fail("octaword mismatch");
  endtask : chk_octa

  task automatic chk_drain(input logic [63:0] v);
    n_checks++;
    if (u_sys.dq.size() == 0) fail("unexpected drain beat");
    else if (u_sys.dq.pop_front() !== v) fail("drain beat mismatch");
  endtask : chk_drain

  task automatic chk_io(input logic [11:0] v);
    n_checks++;
    if (iq.size() == 0) fail("unexpected io command");
    else if (iq.pop_front() !== v) fail("io command mismatch");
  endtask : chk_io

  task automatic chk_val(input int a, input int e, input string m);
    n_checks++;
    if (a != e) fail(m);
  endtask : chk_val

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  // --------------------------------
  // monitor and core-side drain source
  // --------------------------------
  always @(posedge core_clk)
  begin
    if (rst_n && octa_valid === 1'b1) chk_octa(octa);
    if (rst_n && sys_data_out_en === 1'b1) chk_drain(sys_data_out);
    if (rst_n && io_cmd_valid === 1'b1) chk_io({io_cmd_write, outbound_address_bus, outbound_mask});
    if (rst_n && transfer_done === 1'b1) n_done++;
  end

  always @(negedge core_clk) drain_qw <= u_sys.pat(drain_index);

  initial
  begin
    #200000;
    fail("watchdog expired");
    end_sim();
  end

  initial
  begin
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    // back-to-back io requests of every kind, random address and mask
    for (i = 0; i < 8; i++)
    begin
      @(negedge core_clk);
      io_req_valid = 1'b1;
      io_req_write = i[2];
      io_req_kind = sbwrap_pkg::sbwrap_io_kind_t'(i[1:0]);
      io_req_pa = 6'($random(seed));
      io_req_mask = 8'($random(seed));
      iq.push_back({i[2], io_req_pa[5:3], io_req_kind == sbwrap_pkg::SBWRAP_IO_BYTE ?
        8'h01 << io_req_pa[2:0] : io_req_kind == sbwrap_pkg::SBWRAP_IO_WORD ?
        8'h03 << {io_req_pa[2:1], 1'b0} : io_req_mask});
    end
    @(negedge core_clk);
    io_req_valid = 1'b0;
    repeat (3) @(negedge core_clk);
    chk_val(iq.size(), 0, "io commands missing");
    $display("io address and mask test done");
    // start where the outbound address points, the recommended choice
    u_sys.fill(3'h6, outbound_address_bus[2:1], 1'b0, 0);
    // every fill code and start, with growing gaps between octawords
    for (i = 0; i < 4; i++)
      u_sys.fill({1'b1, 2'(i)}, 2'(i), 1'b0, i);
    $display("block fill test done");
    fill_double = 1'b1;
    for (i = 0; i < 4; i++)
      u_sys.fill(3'h4, 2'(i), 1'b1, 1);
    u_sys.fill(3'h4, outbound_address_bus[1:0], 1'b1, 0);
    fill_double = 1'b0;
    $display("double-pumped fill test done");
    // an undefined code must be ignored, beats and all
    u_sys.fill(3'h0, 2'h1, 1'b0, 0);
    repeat (6) @(negedge core_clk);
    for (i = 0; i < 4; i++)
      u_sys.drain(2'(i));
    repeat (4) @(negedge core_clk);
    chk_val(u_sys.oq.size() + u_sys.dq.size(), 0, "transfer beats missing");
    chk_val(n_done, 14, "transfer_done count wrong");
    $display("refusal and drain test done");
    end_sim();
  end
endmodule : testbench
